// >>> hbp_port.v
// Host bus port: bus master, configuration target, parity and irq
//
// Summary of operation
// - Config access with select claims device next clock
// - No claim in six clocks: abort, raise irq
// - Flag parity error one clock after parity
// - Open-drain system error reports fatal errors
// - After grant, wait for frame released
// - Bus clock at most 33 MHz, rising edge
// - Reset puts every output to initial value
// - Irq low from a new pending event or an abort; released on status read
// - Strap 00 plain bus, 10 demultiplexed
// - Demux mode drives separate word address bus
// - Plain mode: top address pin copies clock
// - Write/read line used only in demux mode
// - Even parity over data and command lines
// - Demux: write/read line replaces command code
// - Only first burst address is presented
`timescale 1ns/1ps
`default_nettype none
`include "hbp_regs.vh"

module hbp_port (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Mode strap, tied statically
  input wire [1:0] host_bus_mode_strap,
  // Bus inputs
  input wire [31:0] ad_i,
  input wire [3:0] cbe_i,
  input wire par_i,
  input wire frame_n_i,
  input wire irdy_n_i,
  input wire trdy_n_i,
  input wire stop_n_i,
  input wire devsel_n_i,
  input wire idsel_i,
  input wire gnt_n_i,
  input wire wr_i,
  // Bus outputs and enables
  output reg [31:0] ad_o,
  output reg ad_oe,
  output reg [3:0] cbe_o,
  output reg cbe_oe,
  output reg par_o,
  output reg par_oe,
  output reg frame_n_o,
  output reg irdy_n_o,
  output reg mctl_oe,
  output reg trdy_n_o,
  output reg stop_n_o,
  output reg devsel_n_o,
  output reg tctl_oe,
  output reg perr_n_o,
  output reg perr_oe,
  output reg serr_oe,
  output reg req_n_o,
  output reg inta_oe,
  // Demultiplexed address bus and direction line
  output wire [27:2] a_o,
  output reg a_oe,
  output wire a27_oe,
  output reg wr_o,
  output reg wr_oe,
  // Master requests from the core
  input wire mst_start,
  input wire mst_write,
  input wire [31:0] mst_addr,
  input wire [31:0] mst_wdata,
  input wire [3:0] mst_be_n,
  output reg mst_busy,
  output reg mst_done,
  output reg mst_abort,
  output reg mst_err,
  output reg [31:0] mst_rdata,
  // Configuration register access to the core
  output reg cfg_rd,
  output reg cfg_wr,
  output reg [5:0] cfg_idx,
  output reg [31:0] cfg_wdata,
  output reg [3:0] cfg_be_n,
  input wire [31:0] cfg_rdata,
  // Events and status from the core
  input wire irq_pending,
  input wire stat_rd,
  input wire fatal_err
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam M_IDLE = 5'b00001;
  localparam M_REQ = 5'b00010;
  localparam M_ADDR = 5'b00100;
  localparam M_DATA = 5'b01000;
  localparam M_TURN = 5'b10000;
  localparam T_IDLE = 4'b0001;
  localparam T_ACK = 4'b0010;
  localparam T_DATA = 4'b0100;
  localparam T_TURN = 4'b1000;

  reg [4:0] mst_st_r;
  reg [3:0] tgt_st_r;
  reg [1:0] strap_s1_r;
  reg [1:0] strap_s2_r;
  reg pci_r;
  reg demux_r;
  reg frame_q_r;
  reg [2:0] tmo_r;
  reg wr_lat_r;
  reg [31:0] wdata_r;
  reg [3:0] be_r;
  reg [27:2] a_r;
  reg tgt_wr_r;
  reg [31:0] pad_r;
  reg [3:0] pcbe_r;
  reg chk_dat_r;
  reg chk_adr_r;
  reg pend_q_r;

  // Decodes a configuration command; used for the hit only
  function cfg_cmd;
    input [3:0] c;
    begin
      cfg_cmd = (c == `HBP_CMD_CFG_RD) || (c == `HBP_CMD_CFG_WR);
    end
  endfunction

  wire frame_fall = frame_q_r & ~frame_n_i;
  wire mst_idle = mst_st_r[0] | mst_st_r[1];
  wire tgt_hit = frame_fall & idsel_i & mst_idle &
    (demux_r | cfg_cmd(cbe_i));
  wire tgt_is_wr = demux_r ? wr_i : (cbe_i == `HBP_CMD_CFG_WR);
  wire xfer = ~irdy_n_i & ~trdy_n_i;
  wire par_err = ^{pad_r, pcbe_r, par_i};

  // The clock copy cannot come from a flop without halving its rate
  assign a_o = {pci_r ? core_clk : a_r[27], a_r[26:2]};
  assign a27_oe = pci_r | a_oe;

  // ----------------------------------------------------------------
  // Mode strap, caught through two flops after reset release
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_s1_r <= `HBP_MODE_PCI;
      strap_s2_r <= `HBP_MODE_PCI;
      pci_r <= 1'b0;
      demux_r <= 1'b0;
    end else begin
      strap_s1_r <= host_bus_mode_strap;
      strap_s2_r <= strap_s1_r;
      pci_r <= (strap_s2_r == `HBP_MODE_PCI);
      demux_r <= (strap_s2_r == `HBP_MODE_DEMUX);
    end
  end

  // ----------------------------------------------------------------
  // Master and target sequencers (share the address/data drivers)
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mst_st_r <= M_IDLE;
      tgt_st_r <= T_IDLE;
      frame_q_r <= 1'b1;
      tmo_r <= 3'h0;
      wr_lat_r <= 1'b0;
      wdata_r <= 32'h0;
      be_r <= 4'hF;
      a_r <= 26'h0;
      tgt_wr_r <= 1'b0;
      ad_o <= 32'h0;
      ad_oe <= 1'b0;
      cbe_o <= 4'hF;
      cbe_oe <= 1'b0;
      frame_n_o <= 1'b1;
      irdy_n_o <= 1'b1;
      mctl_oe <= 1'b0;
      trdy_n_o <= 1'b1;
      stop_n_o <= 1'b1;
      devsel_n_o <= 1'b1;
      tctl_oe <= 1'b0;
      req_n_o <= 1'b1;
      a_oe <= 1'b0;
      wr_o <= 1'b1;
      wr_oe <= 1'b0;
      mst_busy <= 1'b0;
      mst_done <= 1'b0;
      mst_abort <= 1'b0;
      mst_err <= 1'b0;
      mst_rdata <= 32'h0;
      cfg_rd <= 1'b0;
      cfg_wr <= 1'b0;
      cfg_idx <= 6'h0;
      cfg_wdata <= 32'h0;
      cfg_be_n <= 4'hF;
    end else begin
      frame_q_r <= frame_n_i;
      mst_done <= 1'b0;
      mst_abort <= 1'b0;
      cfg_rd <= 1'b0;
      cfg_wr <= 1'b0;
      case (mst_st_r)
        M_IDLE: begin
          if (mst_start) begin
            wr_lat_r <= mst_write;
            wdata_r <= mst_wdata;
            be_r <= mst_be_n;
            a_r <= mst_addr[27:2];
            ad_o <= mst_addr;
            req_n_o <= 1'b0;
            mst_busy <= 1'b1;
            mst_err <= 1'b0;
            mst_st_r <= M_REQ;
          end
        end
        M_REQ: begin
          // Bus must be idle, not merely granted
          if (!gnt_n_i && frame_n_i && irdy_n_i &&
              tgt_st_r[0]) begin
            req_n_o <= 1'b1;
            frame_n_o <= 1'b0;
            mctl_oe <= 1'b1;
            ad_oe <= 1'b1;
            cbe_oe <= 1'b1;
            cbe_o <= demux_r ? be_r :
              (wr_lat_r ? `HBP_CMD_MEM_WR : `HBP_CMD_MEM_RD);
            a_oe <= demux_r;
            wr_o <= wr_lat_r;
            wr_oe <= demux_r;
            mst_st_r <= M_ADDR;
          end
        end
        M_ADDR: begin
          // One data phase: the address is never advanced
          frame_n_o <= 1'b1;
          irdy_n_o <= 1'b0;
          cbe_o <= be_r;
          ad_o <= wdata_r;
          ad_oe <= wr_lat_r;
          tmo_r <= 3'h1;
          mst_st_r <= M_DATA;
        end
        M_DATA: begin
          if (tmo_r != `HBP_DEVSEL_TMO) begin
            tmo_r <= tmo_r + 3'h1;
          end
          if (xfer) begin
            mst_rdata <= wr_lat_r ? mst_rdata : ad_i;
            mst_done <= 1'b1;
          end else if (!stop_n_i) begin
            mst_err <= 1'b1;
            mst_done <= 1'b1;
          end else if (devsel_n_i &&
                       tmo_r == `HBP_DEVSEL_TMO) begin
            mst_abort <= 1'b1;
            mst_err <= 1'b1;
            mst_done <= 1'b1;
          end
          if (xfer || !stop_n_i ||
              (devsel_n_i && tmo_r == `HBP_DEVSEL_TMO)) begin
            irdy_n_o <= 1'b1;
            mst_st_r <= M_TURN;
          end
        end
        M_TURN: begin
          mctl_oe <= 1'b0;
          ad_oe <= 1'b0;
          cbe_oe <= 1'b0;
          cbe_o <= 4'hF;
          a_oe <= 1'b0;
          wr_oe <= 1'b0;
          mst_busy <= 1'b0;
          mst_st_r <= M_IDLE;
        end
        default: begin
          mst_st_r <= M_IDLE;
        end
      endcase
      case (tgt_st_r)
        T_IDLE: begin
          if (tgt_hit) begin
            devsel_n_o <= 1'b0;
            tctl_oe <= 1'b1;
            tgt_wr_r <= tgt_is_wr;
            cfg_rd <= ~tgt_is_wr;
            cfg_idx <= ad_i[`HBP_CFG_IDX_HI:`HBP_CFG_IDX_LO];
            tgt_st_r <= T_ACK;
          end
        end
        T_ACK: begin
          // Single-phase target: disconnect with the data
          trdy_n_o <= 1'b0;
          stop_n_o <= 1'b0;
          ad_o <= cfg_rdata;
          ad_oe <= ~tgt_wr_r;
          tgt_st_r <= T_DATA;
        end
        T_DATA: begin
          if (xfer) begin
            cfg_wr <= tgt_wr_r;
            cfg_wdata <= ad_i;
            cfg_be_n <= cbe_i;
            trdy_n_o <= 1'b1;
            stop_n_o <= 1'b1;
            devsel_n_o <= 1'b1;
            tgt_st_r <= T_TURN;
          end
        end
        T_TURN: begin
          tctl_oe <= 1'b0;
          ad_oe <= 1'b0;
          tgt_st_r <= T_IDLE;
        end
        default: begin
          tgt_st_r <= T_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Parity generation and checking, error reporting, interrupt
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pad_r <= 32'h0;
      pcbe_r <= 4'h0;
      chk_dat_r <= 1'b0;
      chk_adr_r <= 1'b0;
      par_o <= 1'b0;
      par_oe <= 1'b0;
      perr_n_o <= 1'b1;
      perr_oe <= 1'b0;
      serr_oe <= 1'b0;
      pend_q_r <= 1'b0;
      inta_oe <= 1'b0;
    end else begin
      // Parity trails the lines it covers by one clock
      par_o <= ^{ad_o, cbe_oe ? cbe_o : cbe_i};
      par_oe <= ad_oe;
      pad_r <= ad_i;
      pcbe_r <= cbe_i;
      chk_adr_r <= tgt_hit;
      chk_dat_r <= xfer & ((tgt_st_r[2] & tgt_wr_r) |
        (mst_st_r[3] & ~wr_lat_r));
      perr_n_o <= ~(chk_dat_r & par_err);
      perr_oe <= chk_dat_r;
      serr_oe <= (chk_adr_r & par_err) | fatal_err;
      pend_q_r <= irq_pending;
      // A new event in the read cycle keeps the line asserted
      inta_oe <= (irq_pending & ~pend_q_r) | mst_abort |
        (inta_oe & ~stat_rd);
    end
  end

endmodule
`default_nettype wire

// >>> hbp_regs.vh
// Constants for the host bus port: commands, strap codes, timing
`ifndef HBP_REGS_VH
`define HBP_REGS_VH

// ----------------------------------------------------------------
// Bus commands on the command/byte-enable lines
// ----------------------------------------------------------------
`define HBP_CMD_MEM_RD 4'h6
`define HBP_CMD_MEM_WR 4'h7
`define HBP_CMD_CFG_RD 4'hA
`define HBP_CMD_CFG_WR 4'hB

// ----------------------------------------------------------------
// Host bus mode strap codes
// ----------------------------------------------------------------
`define HBP_MODE_PCI 2'h0
`define HBP_MODE_DEMUX 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Bus clock ceiling and the rate this block is built for
`define HBP_BUS_FMAX_MHZ 33
`define HBP_CLK_MHZ 25
// Clocks after the address within which a target must claim
`define HBP_DEVSEL_TMO 3'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HBP_CFG_IDX_HI 7
`define HBP_CFG_IDX_LO 2

`endif

// >>> hbp_port_checker.sv
// Concurrent checks on the host bus port pins
`timescale 1ns/1ps
`default_nettype none
`include "hbp_regs.vh"
module hbp_port_checker (
  // Clock, reset and strap
  input wire core_clk, resetn,
  input wire [1:0] host_bus_mode_strap,
  // Bus pins
  input wire [31:0] ad_i,
  input wire [3:0] cbe_i,
  input wire par_i, frame_n_i, irdy_n_i, trdy_n_i, devsel_n_i, idsel_i,
  input wire gnt_n_i, ad_oe, frame_n_o, irdy_n_o, mctl_oe, devsel_n_o,
  input wire tctl_oe, perr_n_o, perr_oe, serr_oe, req_n_o, inta_oe,
  input wire par_o, par_oe,
  // Demultiplexed side
  input wire [27:2] a_o,
  input wire a_oe, a27_oe, wr_o, wr_oe,
  // Core side
  input wire mst_start, mst_write, mst_busy, mst_abort,
  input wire [31:0] mst_addr,
  input wire irq_pending, stat_rd, fatal_err
);
  logic [2:0] up_cnt;
  logic [27:2] addr_r;
  logic wr_r;
  wire mode_ok = up_cnt == 3'h4;
  wire pci = host_bus_mode_strap == `HBP_MODE_PCI;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Strap decode settles a few edges after release
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      up_cnt <= 3'h0;
    end else if (!mode_ok) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  always @(posedge core_clk) begin
    if (mst_start && !mst_busy) begin
      addr_r <= mst_addr[27:2];
      wr_r <= mst_write;
    end
  end
  sequence addr_phase;
    mctl_oe && $fell(frame_n_o);
  endsequence
  sequence rx_data;
    mctl_oe && !irdy_n_o && !trdy_n_i && !ad_oe;
  endsequence
  cfg_claim_a: assert property (
    $fell(frame_n_i) && idsel_i && cbe_i[3:1] == 3'h5 && !mst_busy
    && mode_ok && pci |=> !devsel_n_o && tctl_oe)
    else $error("config access not claimed");
  no_claim_a: assert property (
    addr_phase ##0 devsel_n_i [*7] |-> ##[1:2] mst_abort)
    else $error("unclaimed transfer not aborted");
  abort_irq_a: assert property (mst_abort |=> inta_oe)
    else $error("abort did not raise irq");
  parity_flag_a: assert property (rx_data |-> ##2 perr_oe &&
    perr_n_o == !(^{$past(ad_i, 2), $past(cbe_i, 2), $past(par_i)}))
    else $error("parity error flag wrong");
  serr_fatal_a: assert property (fatal_err |=> serr_oe)
    else $error("fatal error not reported");
  par_drive_a: assert property (ad_oe |=> par_oe &&
    par_o == ^{$past(ad_i), $past(cbe_i)})
    else $error("driven parity wrong");
  bus_take_a: assert property ($rose(mctl_oe) |-> $past(!gnt_n_i) &&
    $past(frame_n_i) && $past(irdy_n_i) && $past(!req_n_o))
    else $error("bus taken without grant or idle");
  reset_idle_a: assert property ($rose(resetn) |-> !ad_oe &&
    !mctl_oe && !tctl_oe && !inta_oe && !serr_oe && !perr_oe
    && req_n_o && !a_oe && !wr_oe)
    else $error("outputs not idle after reset");
  irq_set_a: assert property ($rose(irq_pending) |=> inta_oe)
    else $error("irq not raised");
  irq_clear_a: assert property (
    stat_rd && !irq_pending && !mst_abort |=> !inta_oe)
    else $error("irq not released on status read");
  clock_copy_a: assert property (@(negedge core_clk)
    disable iff (!resetn) pci && mode_ok |-> a27_oe && a_o[27])
    else $error("clock copy missing");
  wr_idle_a: assert property (pci && mode_ok |-> !wr_oe)
    else $error("direction line driven in plain mode");
  demux_addr_a: assert property (
    host_bus_mode_strap == `HBP_MODE_DEMUX && mode_ok && mctl_oe
    && !frame_n_o |-> a_oe && a_o == addr_r && wr_oe && wr_o == wr_r)
    else $error("demux address or direction wrong");
endmodule
bind hbp_port hbp_port_checker chk (.*);
`default_nettype wire

// >>> hbp_bus_model.sv
// Far side: arbiter plus a memory target answering the port's master
`timescale 1ns/1ps
`default_nettype none
module hbp_bus_model (
  // Clock and reset
  input wire logic core_clk, resetn,
  // Master signals from the port
  input wire logic req_n_o, frame_n_o, irdy_n_o, mctl_oe,
  // Target behaviour chosen by the bench
  input wire logic claim,
  input wire logic [2:0] lag,
  // Answers, released lines float high by pull-up
  output logic gnt_n, devsel_n, trdy_n
);
  logic act;
  logic [2:0] cnt;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gnt_n <= 1'b1;
      act <= 1'b0;
      cnt <= 3'h0;
    end else begin
      gnt_n <= req_n_o;
      if (mctl_oe && !frame_n_o && !act) begin
        act <= claim;
        cnt <= 3'h0;
      end else if (act && (trdy_n || irdy_n_o)) begin
        cnt <= cnt + 3'h1;
      end else begin
        act <= 1'b0;
      end
    end
  end
  assign devsel_n = !(act && cnt >= lag);
  assign trdy_n = !(act && cnt > lag);
endmodule
`default_nettype wire

// >>> pci_demux_host_bus_port_tb.sv
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
`include "hbp_regs.vh"
module pci_demux_host_bus_port_tb;
  logic core_clk, resetn, idsel_i, tb_frame, tb_irdy, bad, mst_start;
  logic mst_write, stat_rd, irq_pending, fatal_err, claim, par_i;
  logic [1:0] host_bus_mode_strap;
  logic [2:0] lag;
  logic [3:0] tb_cbe, mst_be_n;
  logic [31:0] tb_ad, mst_addr, mst_wdata, cfg_rdata;
  integer seed, error_cnt, cmp_count, perr_cnt, i, k;
  wire [31:0] ad_o, ad_i, mst_rdata, cfg_wdata;
  wire [3:0] cbe_o, cbe_i, cfg_be_n;
  wire [5:0] cfg_idx;
  wire [27:2] a_o;
  wire ad_oe, cbe_oe, par_o, par_oe, frame_n_o, irdy_n_o, mctl_oe;
  wire trdy_n_o, stop_n_o, devsel_n_o, tctl_oe, perr_n_o, perr_oe;
  wire serr_oe, req_n_o, inta_oe, a_oe, a27_oe, wr_o, wr_oe, mst_busy;
  wire mst_done, mst_abort, mst_err, cfg_rd, cfg_wr, gnt_n_i, m_dev, m_trdy;
  wire stop_n_i = 1'b1;
  logic wr_i, dmx;
  assign ad_i = ad_oe ? ad_o : tb_ad;
  assign cbe_i = cbe_oe ? cbe_o : tb_cbe;
  wire frame_n_i = mctl_oe ? frame_n_o : tb_frame;
  wire irdy_n_i = mctl_oe ? irdy_n_o : tb_irdy;
  wire devsel_n_i = tctl_oe ? devsel_n_o : m_dev;
  wire trdy_n_i = tctl_oe ? trdy_n_o : m_trdy;
  hbp_port dut (.*);
  hbp_bus_model bus (.core_clk, .resetn, .req_n_o, .frame_n_o, .irdy_n_o,
    .mctl_oe, .claim, .lag, .gnt_n(gnt_n_i), .devsel_n(m_dev),
    .trdy_n(m_trdy));
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  // Even parity one clock behind, bad flips it on purpose
  always @(posedge core_clk) par_i <= ^{ad_i, cbe_i} ^ bad;
  always @(posedge core_clk) if (perr_oe && !perr_n_o) perr_cnt++;
  task chk(input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // A claim needs a config command, or any command on the demux bus
  function automatic logic exp_hit(input logic [3:0] c);
    exp_hit = dmx || c[3:1] == 3'h5;
  endfunction
  task tick;
    @(posedge core_clk);
    #1;
  endtask
  task give_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task rst(input logic [1:0] m);
    resetn = 0;
    host_bus_mode_strap = m;
    repeat (6) tick;
    resetn = 1;
    repeat (4) tick;
  endtask
  // One master word; d is write data or what the target returns
  task mst(input logic w, logic [31:0] a, d, logic e);
    mst_write = w;
    mst_addr = a;
    mst_wdata = d;
    tb_ad = d;
    mst_be_n = 4'h0;
    mst_start = 1;
    tick;
    mst_start = 0;
    for (k = 0; k < 40 && mst_done !== 1'b1; k++) tick;
    chk(1, mst_done);
    chk(e, mst_err);
    for (k = 0; k < 5 && mst_busy !== 1'b0; k++) tick;
    if (!w && !e) chk(d, mst_rdata);
  endtask
  task cfg(input logic [3:0] c, logic [5:0] x, logic [31:0] d);
    logic hit;
    hit = exp_hit(c);
    tb_frame = 0;
    idsel_i = 1;
    wr_i = c[0];
    tb_cbe = c;
    tb_ad = {24'h0, x, 2'h0};
    tick;
    tb_frame = 1;
    idsel_i = 0;
    tb_irdy = 0;
    tb_cbe = 4'hF ^ c;
    tb_ad = d;
    chk(!hit, devsel_n_o);
    chk(hit && !c[0], cfg_rd);
    if (hit) chk(x, cfg_idx);
    tick;
    if (hit && !c[0]) chk(cfg_rdata, ad_o);
    tick;
    tb_irdy = 1;
    chk(hit && c[0], cfg_wr);
    if (hit && c[0]) chk(d, cfg_wdata);
    if (hit && c[0]) chk(4'hF ^ c, cfg_be_n);
    repeat (3) tick;
  endtask
  initial begin
    seed = 47023;
    error_cnt = 0;
    cmp_count = 0;
    perr_cnt = 0;
    {mst_start, mst_write, stat_rd, irq_pending, fatal_err, bad, dmx} = 7'h00;
    {resetn, idsel_i, lag} = 5'h00;
    {tb_frame, tb_irdy, claim, wr_i} = 4'hF;
    tb_cbe = 4'hF;
    tb_ad = 0;
    mst_addr = 0;
    mst_wdata = 0;
    mst_be_n = 0;
    host_bus_mode_strap = `HBP_MODE_PCI;
    cfg_rdata = $random(seed);
    rst(`HBP_MODE_PCI);
    for (i = 0; i < 6; i++) begin
      lag = $random(seed) & 3;
      mst(i[0], $random(seed), $random(seed), 0);
    end
    chk(0, perr_cnt);
    bad = 1;
    mst(0, 32'h10, 32'h5A5A0F0F, 0);
    bad = 0;
    repeat (2) tick;
    chk(1, perr_cnt);
    claim = 0;
    mst(1, 32'h20, 32'h1, 1);
    claim = 1;
    tick;
    chk(1, inta_oe);
    stat_rd = 1;
    tick;
    stat_rd = 0;
    chk(0, inta_oe);
    irq_pending = 1;
    repeat (2) tick;
    chk(1, inta_oe);
    irq_pending = 0;
    stat_rd = 1;
    tick;
    stat_rd = 0;
    chk(0, inta_oe);
    fatal_err = 1;
    tick;
    fatal_err = 0;
    chk(1, serr_oe);
    for (i = 0; i < 4; i++) begin
      cfg(i[1] ? 4'h6 + i[0] : 4'hA + i[0], $random(seed),
        $random(seed));
    end
    rst(`HBP_MODE_DEMUX);
    mst(1, 32'h0ABCDEF4, 32'h3, 0);
    mst(0, 32'h01234560, 32'h77, 0);
    dmx = 1;
    cfg(4'h6, $random(seed), $random(seed));
    cfg(4'h7, $random(seed), $random(seed));
    give_verdict;
  end
  initial begin
    #100000;
    error_cnt++;
    give_verdict;
  end
endmodule
`default_nettype wire
